// ===== design/sacc_defs.svh
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
// register byte offsets
`define SACC_OFS_CTRL 12'h000
`define SACC_OFS_MUX 12'h004
`define SACC_OFS_COMMAND 12'h008
`define SACC_OFS_FLAGS 12'h00C
`define SACC_OFS_INTCTRL 12'h010
`define SACC_OFS_RESULT 12'h014
`define SACC_OFS_STATUS 12'h018
// control register fields
`define SACC_CTRL_ENABLE 0
`define SACC_CTRL_START_EVENT_INPUT_ENABLE 1
`define SACC_CTRL_DEBUG_RUN_ENABLE 2
`define SACC_CTRL_RESOLUTION_SELECT 3
`define SACC_CTRL_REF_LSB 4
`define SACC_CTRL_DIV_LSB 8
`define SACC_CTRL_ACC_LSB 12
// reset values
`define SACC_REF_RESET 2'h0
`define SACC_DIV_RESET 3'h0
`define SACC_ACC_RESET 3'h0
`define SACC_CH_RESET 4'h0
// conversion length in conversion-clock cycles, and the cap on the accumulation count select
`define SACC_CONV_CYCLES 4'hD
`define SACC_ACC_MAX 3'h6
`endif

// ===== design/sacc_pkg.sv
package sacc_pkg;
	typedef enum logic [1:0] {
		SACC_IDLE = 2'b00,
		SACC_WAIT = 2'b01,
		SACC_CONV = 2'b10
	} sacc_state_type;
endpackage : sacc_pkg

// ===== design/sacc_divider.sv
// conversion clock tick from pclk by power-of-two division
module sacc_divider (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic run,
	input wire logic restart,
	input wire logic [2:0] div_sel,
	output logic tick
);
	typedef struct packed {
		logic [8:0] cnt;
		logic tick;
	} sacc_div_type;

	sacc_div_type cur;
	sacc_div_type next_cur;
	logic [8:0] limit;
	// shift amount widened so the top setting does not wrap to zero
	assign limit = 9'((9'h001 << ({1'b0, div_sel} + 4'h1)) - 9'h001);

	always_comb begin
		next_cur = cur;
		next_cur.tick = 1'b0;
		if (!run || restart) begin
			next_cur.cnt = 9'h000;
		end else if (cur.cnt >= limit) begin
			next_cur.cnt = 9'h000;
			next_cur.tick = 1'b1;
		end else begin
			next_cur.cnt = 9'(cur.cnt + 9'h001);
		end
	end

	// clock enable low holds the count instead of clearing it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign tick = cur.tick;
endmodule : sacc_divider

// ===== design/sacc_core.sv
`include "sacc_defs.svh"
module sacc_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic start_event,
	input wire logic debug_halt,
	input wire logic touch_controller_active,
	input wire logic [9:0] sar_sample,
	output logic [3:0] input_channel_active,
	output logic [1:0] reference_active,
	output logic sample_hold,
	output logic irq
);
	import sacc_pkg::*;

	typedef struct packed {
		logic enable;
		logic start_event_input_enable;
		logic debug_run_enable;
		logic resolution_select;
		logic [1:0] reference_select;
		logic [2:0] clock_divider_select;
		logic [2:0] accumulation_count_select;
		logic [3:0] input_channel_select;
		logic [3:0] chan_act;
		logic [1:0] ref_act;
		logic start_conversion_bit;
		logic from_event;
		logic result_ready_flag;
		logic result_ready_int_enable;
		sacc_state_type state;
		logic [3:0] cyc;
		logic [6:0] samples_left;
		logic [15:0] acc;
		logic [15:0] result;
		logic ev_s1;
		logic ev_s2;
		logic ev_prev;
		logic dbg_s1;
		logic dbg_s2;
		logic tch_s1;
		logic tch_s2;
		logic sample_hold;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sacc_regs_type;

	sacc_regs_type cur;
	sacc_regs_type next_cur;
	logic tick;
	logic restart;
	logic run;

	function automatic logic [6:0] sample_total(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > `SACC_ACC_MAX) ? `SACC_ACC_MAX : sel;
		sample_total = 7'(7'h01 << s);
	endfunction : sample_total

	function automatic logic valid_channel(input logic [3:0] ch);
		valid_channel = (ch <= 4'hD); // pins 0-11, 12 ground, 13 internal reference
	endfunction : valid_channel

	// frozen in debug halt unless the debug run bit is set
	assign run = cur.enable && (!cur.dbg_s2 || cur.debug_run_enable);

	sacc_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.run(run),
		.restart(restart),
		.div_sel(cur.clock_divider_select),
		.tick(tick)
	);

	logic access;
	logic wr;
	logic rd;
	logic ev_edge;
	logic sw_start;
	logic start_req;
	assign access = psel && penable && !cur.pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign ev_edge = cur.ev_s2 && !cur.ev_prev;
	assign sw_start = wr && (paddr == `SACC_OFS_COMMAND) && pwdata[0] && !cur.start_event_input_enable;
	// touch controller owns the converter, so user starts are dropped
	assign start_req = run && !cur.tch_s2 && (cur.state == SACC_IDLE) && (sw_start || (ev_edge
		&& cur.start_event_input_enable));
	assign restart = clk_en && start_req;

	always_comb begin
		logic done;
		logic mapped;
		done = 1'b0;
		mapped = 1'b1;
		next_cur = cur;
		next_cur.pready = 1'b0;
		next_cur.pslverr = 1'b0;
		next_cur.ev_s1 = start_event;
		next_cur.ev_s2 = cur.ev_s1;
		next_cur.ev_prev = cur.ev_s2;
		next_cur.dbg_s1 = debug_halt;
		next_cur.dbg_s2 = cur.dbg_s1;
		next_cur.tch_s1 = touch_controller_active;
		next_cur.tch_s2 = cur.tch_s1;
		next_cur.sample_hold = 1'b0;

		// selections track while idle and enabled, locked during conversion
		if (cur.enable && cur.state == SACC_IDLE) begin
			next_cur.chan_act = cur.input_channel_select;
			next_cur.ref_act = cur.reference_select;
		end

		if (start_req) begin
			next_cur.start_conversion_bit = 1'b1;
			next_cur.from_event = !sw_start;
			next_cur.state = SACC_WAIT;
			next_cur.samples_left = sample_total(cur.accumulation_count_select);
			next_cur.acc = 16'h0000;
		end

		if (run) begin
			case (cur.state)
				SACC_IDLE: begin
				end
				SACC_WAIT: begin
					if (tick) begin
						next_cur.state = SACC_CONV;
						next_cur.cyc = 4'h1;
					end
				end
				SACC_CONV: begin
					if (tick) begin
						if (cur.cyc == 4'h2) begin
							next_cur.sample_hold = 1'b1;
						end
						if (cur.cyc == `SACC_CONV_CYCLES) begin
							next_cur.acc = 16'(cur.acc + (cur.resolution_select ? {8'h00, sar_sample[9:2]} :
								{6'h00, sar_sample}));
							next_cur.samples_left = 7'(cur.samples_left - 7'h01);
							next_cur.cyc = 4'h1;
							if (cur.samples_left == 7'h01) begin
								done = 1'b1;
							end
						end else begin
							next_cur.cyc = 4'(cur.cyc + 4'h1);
						end
					end
				end
				default: next_cur.state = SACC_IDLE;
			endcase
		end else if (!cur.enable) begin
			next_cur.state = SACC_IDLE;
			next_cur.start_conversion_bit = 1'b0;
		end

		if (done) begin
			next_cur.state = SACC_IDLE;
			next_cur.result = 16'(cur.acc + (cur.resolution_select ? {8'h00, sar_sample[9:2]} :
				{6'h00, sar_sample}));
			next_cur.start_conversion_bit = 1'b0;
			next_cur.chan_act = cur.input_channel_select;
		end

		if (access) begin
			next_cur.pready = 1'b1;
			next_cur.prdata = 32'h00000000;
			case (paddr)
				`SACC_OFS_CTRL: begin
					next_cur.prdata = {17'h00000, cur.accumulation_count_select, 1'b0, cur.clock_divider_select,
						2'h0, cur.reference_select, cur.resolution_select, cur.debug_run_enable,
						cur.start_event_input_enable, cur.enable};
					if (pwrite) begin
						next_cur.enable = pwdata[`SACC_CTRL_ENABLE];
						next_cur.start_event_input_enable = pwdata[`SACC_CTRL_START_EVENT_INPUT_ENABLE];
						next_cur.debug_run_enable = pwdata[`SACC_CTRL_DEBUG_RUN_ENABLE];
						next_cur.resolution_select = pwdata[`SACC_CTRL_RESOLUTION_SELECT];
						next_cur.reference_select = pwdata[`SACC_CTRL_REF_LSB +: 2];
						next_cur.clock_divider_select = pwdata[`SACC_CTRL_DIV_LSB +: 3];
						next_cur.accumulation_count_select = pwdata[`SACC_CTRL_ACC_LSB +: 3];
					end
				end
				`SACC_OFS_MUX: begin
					next_cur.prdata = {28'h0000000, cur.input_channel_select};
					if (pwrite && valid_channel(pwdata[3:0])) begin
						next_cur.input_channel_select = pwdata[3:0];
					end
				end
				`SACC_OFS_COMMAND: next_cur.prdata = {31'h00000000, cur.start_conversion_bit};
				`SACC_OFS_FLAGS: begin
					next_cur.prdata = {31'h00000000, cur.result_ready_flag};
					if (pwrite && pwdata[0]) begin
						next_cur.result_ready_flag = 1'b0;
					end
				end
				`SACC_OFS_INTCTRL: begin
					next_cur.prdata = {31'h00000000, cur.result_ready_int_enable};
					if (pwrite) begin
						next_cur.result_ready_int_enable = pwdata[0];
					end
				end
				`SACC_OFS_RESULT: begin
					next_cur.prdata = {16'h0000, cur.result};
					if (!pwrite) begin
						next_cur.result_ready_flag = 1'b0;
					end
				end
				`SACC_OFS_STATUS: next_cur.prdata = {24'h000000, cur.ref_act, cur.chan_act, cur.state};
				default: mapped = 1'b0;
			endcase
			next_cur.pslverr = !mapped;
		end

		// set wins over a clear in the same cycle
		if (done) begin
			next_cur.result_ready_flag = 1'b1;
		end
		next_cur.irq = next_cur.result_ready_flag && next_cur.result_ready_int_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
			cur.reference_select <= `SACC_REF_RESET;
			cur.ref_act <= `SACC_REF_RESET;
			cur.clock_divider_select <= `SACC_DIV_RESET;
			cur.accumulation_count_select <= `SACC_ACC_RESET;
			cur.input_channel_select <= `SACC_CH_RESET;
			cur.chan_act <= `SACC_CH_RESET;
			cur.state <= SACC_IDLE;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;
	assign input_channel_active = cur.chan_act;
	assign reference_active = cur.ref_act;
	assign sample_hold = cur.sample_hold;
	assign irq = cur.irq;
endmodule : sacc_core

// ===== testbench/sacc_partner.sv
module sacc_partner (
	input wire logic pclk,
	input wire logic fire,
	input wire logic [3:0] input_channel_active,
	output logic start_event,
	output logic [9:0] sar_sample
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt = 3'h0;
	// event held 4 cycles so the 2-FF sync cannot miss it
	always @(posedge pclk) cnt <= fire ? 3'h4 : (cnt != 3'h0 ? cnt - 3'h1 : cnt);
	assign start_event = cnt != 3'h0;
	// code differs per channel, so a wrong mux shows in the result
	assign sar_sample = {input_channel_active, 6'h15};
endmodule : sacc_partner

// ===== testbench/sacc_core_asserts.sv
module sacc_core_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] input_channel_active,
	input wire logic [1:0] reference_active,
	input wire logic sample_hold,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	property p_ready_cause; pready |-> psel && penable && $past(psel && penable); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_chan_range; input_channel_active <= 4'hD; endproperty
	a_chan_range: assert property (p_chan_range) else $error("channel out of range");
	property p_hold_gap; sample_hold |=> !sample_hold [*8]; endproperty
	a_hold_gap: assert property (p_hold_gap) else $error("samples too close");
	property p_chan_lock; sample_hold |=> ($stable(input_channel_active) && $stable(reference_active)) [*8]; endproperty
	a_chan_lock: assert property (p_chan_lock) else $error("selection moved mid conversion");
	property p_reset_out; $rose(presetn) |-> reference_active == 2'h0 && input_channel_active == 4'h0 && !irq; endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
	property p_irq_clear; pready && !pwrite && !pslverr && paddr == 12'h014 |=> !irq; endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq stays after result read");
endmodule : sacc_core_asserts
bind sacc_core sacc_core_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .input_channel_active, .reference_active, .sample_hold, .irq);

// ===== testbench/sacc_tb_top.sv
module sacc_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, e;
	logic dbg = 1'b0, tch = 1'b0, cen = 1'b1;
	int n_hold = 0, holds;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, start_event, sample_hold, irq;
	logic [9:0] sar_sample;
	logic [3:0] chan;
	logic [1:0] ref_sel;
	int n_mismatch = 0, comparisons = 0;
	typedef struct {logic [3:0] ch; logic [31:0] res;} sacc_row_type;
	sacc_row_type rows [4] = '{'{4'h0, 32'h15}, '{4'hB, 32'h2D5}, '{4'hC, 32'h315}, '{4'hD, 32'h355}};
	always #5 pclk = ~pclk;
	// counts sample-and-hold pulses, one per sample taken
	always @(posedge pclk) if (sample_hold === 1'b1) n_hold++;
	sacc_core DUT (.pclk, .presetn, .clk_en(cen), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .start_event, .debug_halt(dbg), .touch_controller_active(tch), .sar_sample,
		.input_channel_active(chan), .reference_active(ref_sel), .sample_hold, .irq);
	sacc_partner u_far (.pclk, .fire, .input_channel_active(chan), .start_event, .sar_sample);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask : rd
	task automatic wait_idle;
		do begin
			apb(1'b0, 12'h008, 32'h0);
		end while (q[0] !== 1'b0);
	endtask : wait_idle
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("status", 12'h018, 32'h0);
		chk("ref pin", 32'h0, {30'h0, ref_sel});
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		foreach (rows[i]) begin
			apb(1'b1, 12'h004, {28'h0, rows[i].ch});
			apb(1'b1, 12'h008, 32'h1);
			rd("busy", 12'h008, 32'h1);
			wait_idle();
			rd("flag", 12'h00C, 32'h1);
			rd("result", 12'h014, rows[i].res);
			rd("flag", 12'h00C, 32'h0);
			chk("irq", 32'h0, {31'h0, irq});
			$display("row %0d done", i);
		end
		apb(1'b1, 12'h004, 32'hE);
		rd("mux", 12'h004, 32'hD);
		// second start and mux write land mid-run
		holds = n_hold;
		apb(1'b1, 12'h000, 32'h2001);
		apb(1'b1, 12'h008, 32'h1);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h008, 32'h1);
		wait_idle();
		rd("sum", 12'h014, 32'hD54);
		rd("status", 12'h018, 32'h0);
		chk("holds", 32'h4, 32'(n_hold - holds));
		chk("chan pin", 32'h0, {28'h0, chan});
		$display("accumulate test done");
		apb(1'b1, 12'h000, 32'h3);
		apb(1'b1, 12'h010, 32'h1);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (6) @(posedge pclk);
		rd("busy", 12'h008, 32'h1);
		wait_idle();
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, 12'h00C, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		rd("result", 12'h014, 32'h15);
		rd("unmapped", 12'h01C, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		$display("event and error tests done");
		apb(1'b1, 12'h008, 32'h1);
		rd("busy", 12'h008, 32'h0);
		tch <= 1'b1;
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h008, 32'h1);
		rd("busy", 12'h008, 32'h0);
		tch <= 1'b0;
		// let the owner release pass the two-stage sync
		repeat (2) @(posedge pclk);
		apb(1'b1, 12'h008, 32'h1);
		dbg <= 1'b1;
		repeat (100) @(posedge pclk);
		rd("halted busy", 12'h008, 32'h1);
		dbg <= 1'b0;
		wait_idle();
		rd("result", 12'h014, 32'h15);
		apb(1'b1, 12'h000, 32'h5);
		dbg <= 1'b1;
		apb(1'b1, 12'h008, 32'h1);
		repeat (60) @(posedge pclk);
		rd("flag", 12'h00C, 32'h1);
		rd("result", 12'h014, 32'h15);
		dbg <= 1'b0;
		$display("owner and debug tests done");
		apb(1'b1, 12'h008, 32'h1);
		cen <= 1'b0;
		repeat (100) @(posedge pclk);
		cen <= 1'b1;
		rd("frozen busy", 12'h008, 32'h1);
		wait_idle();
		rd("result", 12'h014, 32'h15);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h004, 32'h5);
		chk("chan pin", 32'h0, {28'h0, chan});
		apb(1'b1, 12'h000, 32'h109);
		chk("chan pin", 32'h5, {28'h0, chan});
		apb(1'b1, 12'h008, 32'h1);
		// divide-by-two run would be done by now, divide by four is not
		repeat (40) @(posedge pclk);
		rd("divided busy", 12'h008, 32'h1);
		wait_idle();
		rd("8-bit result", 12'h014, 32'h55);
		$display("freeze, enable and divider tests done");
		end_sim();
	end
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
endmodule : sacc_tb_top
